// [bench/tb_tpcpwm.sv]
// Self-checking bench for the three-phase PWM block.
// Assumes the AXI4-Lite slave map of the package and prescaler left at 0.
`timescale 1ns/1ps
module tb_tpcpwm;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d, acc_or, acc_and;
    logic [5:0]  pwm_q, pwm_en_q, prev_q;
    logic [15:0] shoot_cnt, dead_cnt, c4;
    logic [15:0] rises [6];
    logic        counting = 1'b0;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    always #2.5 aclk = ~aclk;

    tpcpwm #(.CW(16)) tpcpwm_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_q(pwm_q), .pwm_en_q(pwm_en_q)
    );

    tpcpwm_stage_model tpcpwm_stage_model_inst (
        .aclk(aclk), .aresetn(aresetn), .pwm_q(pwm_q),
        .pwm_en_q(pwm_en_q), .shoot_cnt(shoot_cnt), .dead_cnt(dead_cnt)
    );

    always @(posedge aclk) begin
        prev_q <= pwm_q;
        cyc <= cyc + 1;
        if (counting) begin
            for (int i = 0; i < 6; i++) begin
                if (pwm_q[i] && !prev_q[i]) begin
                    rises[i] <= rises[i] + 16'h0001;
                end
            end
        end
        // Ceiling well above the under 800 cycles the tests need
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Handshake is judged on the level held just before the rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        hr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr) begin
            @(negedge aclk);
            ha = arvalid & arready;
            hr = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask

    task automatic count_win(input int n);
        @(posedge aclk);
        for (int i = 0; i < 6; i++) rises[i] <= 16'h0000;
        counting <= 1'b1;
        repeat (n) @(posedge aclk);
        counting <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(tpcpwm_pkg::OFF_CNT3);
        chk("cnt3_rst", d, 32'h00000000);
        chk("rd_resp", {30'h0, r}, 32'h00000000);
        chk("idle_pin_en", {26'h0, pwm_en_q}, 32'h00000000);
        rd(tpcpwm_pkg::OFF_PH1);
        chk("ph1_rst", d, {16'h0000, tpcpwm_pkg::CMP_RESET});
        rd(8'h40);
        chk("unmapped_resp", {30'h0, r}, 32'h00000002);
        chk("unmapped_data", d, 32'h00000000);
        wr(8'h40, 32'h00000001);
        chk("wr_unmapped", {30'h0, r}, 32'h00000002);
        $display("test reset_values done");

        wr(tpcpwm_pkg::OFF_CTRL, 32'h00000018);
        chk("wr_resp", {30'h0, r}, 32'h00000000);
        wr(tpcpwm_pkg::OFF_CNT3, 32'h00000000);
        wr(tpcpwm_pkg::OFF_PERIOD, 32'h00000009);
        wr(tpcpwm_pkg::OFF_PH1, 32'h00000003);
        wr(tpcpwm_pkg::OFF_PH2, 32'h00000005);
        // Third phase beyond the period: no match, so no edges
        wr(tpcpwm_pkg::OFF_PH3, 32'h0000000b);
        wr(tpcpwm_pkg::OFF_CTRL, 32'h0000001b);
        @(negedge aclk);
        chk("rs_pin_en", {26'h0, pwm_en_q}, 32'h0000003f);
        count_win(100);
        chk("rs_rise1p", {16'h0, rises[0]}, 32'h0000000a);
        chk("rs_rise1n", {16'h0, rises[1]}, 32'h0000000a);
        chk("rs_rise2p", {16'h0, rises[2]}, 32'h0000000a);
        chk("rs_rise2n", {16'h0, rises[3]}, 32'h0000000a);
        chk("rs_rise3p", {16'h0, rises[4]}, 32'h00000000);
        chk("rs_rise3n", {16'h0, rises[5]}, 32'h00000000);
        for (int k = 0; k < 5; k++) begin
            rd(tpcpwm_pkg::OFF_CNT3);
            chk("rs_cnt3_le", {31'h0, d <= 32'h9}, 32'h1);
        end
        rd(tpcpwm_pkg::OFF_CNT4);
        c4 = d[15:0];
        rd(tpcpwm_pkg::OFF_CNT4);
        chk("ch4_runs", {31'h0, d[15:0] != c4}, 32'h1);
        rd(tpcpwm_pkg::OFF_PH2);
        chk("ph2_kept", d, 32'h00000005);
        $display("test reset_sync done");

        wr(tpcpwm_pkg::OFF_CTRL, 32'h00000018);
        wr(tpcpwm_pkg::OFF_CTRL, 32'h0000002c);
        wr(tpcpwm_pkg::OFF_CNT4, 32'h00000000);
        wr(tpcpwm_pkg::OFF_CNT3, 32'h00000002);
        wr(tpcpwm_pkg::OFF_PERIOD, 32'h00000014);
        wr(tpcpwm_pkg::OFF_PH1, 32'h00000008);
        wr(tpcpwm_pkg::OFF_PH2, 32'h0000000a);
        wr(tpcpwm_pkg::OFF_PH3, 32'h0000001e);
        wr(tpcpwm_pkg::OFF_SH1, 32'h00000008);
        wr(tpcpwm_pkg::OFF_SH2, 32'h0000000a);
        wr(tpcpwm_pkg::OFF_SH3, 32'h0000001e);
        wr(tpcpwm_pkg::OFF_STATUS, 32'h00000000);
        wr(tpcpwm_pkg::OFF_CTRL, 32'h0000002f);
        @(negedge aclk);
        chk("cp_pin_en", {26'h0, pwm_en_q}, 32'h0000003f);
        count_win(200);
        chk("cp_rise1p", {31'h0, rises[0] != 16'h0}, 32'h1);
        chk("cp_rise1n", {31'h0, rises[1] != 16'h0}, 32'h1);
        chk("cp_rise3p", {16'h0, rises[4]}, 32'h00000000);
        chk("cp_rise3n", {16'h0, rises[5]}, 32'h00000000);
        chk("cp_shoot", {16'h0, shoot_cnt}, 32'h00000000);
        chk("cp_dead", {31'h0, dead_cnt != 16'h0}, 32'h1);
        acc_or = 32'h0;
        acc_and = 32'hffffffff;
        for (int k = 0; k < 40; k++) begin
            rd(tpcpwm_pkg::OFF_STATUS);
            acc_or |= d;
            acc_and &= d;
        end
        chk("cp_flags_set", {29'h0, acc_or[2:0]}, 32'h7);
        chk("cp_dir_turns", {31'h0, acc_and[2]}, 32'h0);
        wr(tpcpwm_pkg::OFF_SH1, 32'h0000000c);
        d = 32'h0;
        for (int k = 0; k < 60 && d !== 32'h0000000c; k++) begin
            rd(tpcpwm_pkg::OFF_PH1);
        end
        chk("cp_shadow_copy", d, 32'h0000000c);
        $display("test complementary done");
        summarize();
    end
endmodule

// [bench/tpcpwm_stage_model.sv]
// Power stage model for the three output legs of the PWM block.
// Assumes the six pin levels are sampled on aclk; counts cycles in which
// a driven leg has both switches on, or both off.
`timescale 1ns/1ps
module tpcpwm_stage_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  pwm_q,
    input  wire logic [5:0]  pwm_en_q,
    output logic      [15:0] shoot_cnt,
    output logic      [15:0] dead_cnt
);
    logic shoot;
    logic dead;
    always @(posedge aclk) begin
        shoot = 1'b0;
        dead  = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (pwm_en_q[2*i]) begin
                // Both switches on would short the supply rail
                shoot |= pwm_q[2*i] & pwm_q[2*i+1];
                dead  |= ~pwm_q[2*i] & ~pwm_q[2*i+1];
            end
        end
        if (!aresetn) begin
            shoot_cnt <= 16'h0000;
            dead_cnt  <= 16'h0000;
        end else begin
            shoot_cnt <= shoot_cnt + {15'h0000, shoot};
            dead_cnt  <= dead_cnt + {15'h0000, dead};
        end
    end
endmodule

// [hdl/tpcpwm.sv]
// Three-phase PWM generator: reset-synchronized and complementary modes,
// with an AXI4-Lite register slave and buffered compare updates.
// Assumes synchronous inputs on aclk and software keeping mode-change rules.
//
// Overview of operation
// - Reset-sync: clear on period match, ch3 counts up, returns to zero.
// - Reset-sync mode code makes all six pins PWM outputs.
// - Reset-sync: ch4 free-runs, does not touch phase 2/3 compares.
// - Reset-sync: outputs toggle on phase match and on period clear.
// - Complementary: down at period match, up at ch4 underflow.
// - Matches occur ch3, ch4, ch4, ch3; ch3 stays above ch4.
// - Complementary: negative is inverse of positive with non-overlap gap.
// - Compare beyond period gives constant 0% or 100% duty.
// - Match-A flag only when incrementing; wrap flag on underflow, or on ch4 overflow outside complementary.
// - Complementary: shadow copies on up period match or ch4 underflow.
`timescale 1ns/1ps
module tpcpwm #(
    parameter int CW = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [5:0]       pwm_q,
    output logic [5:0]       pwm_en_q
);
    if (CW != 16) $error("tpcpwm: counter width must be 16");

    logic [5:0]  ctrl_q, ctrl_d;
    logic [15:0] c3_q, c3_d, c4_q, c4_d, per_q, per_d, presc_q, presc_d;
    logic [15:0] pre_cnt_q, pre_cnt_d;
    logic [15:0] cmp_q [3], cmp_d [3], sh_q [3], sh_d [3];
    logic [2:0]  pos_q, pos_d, neg_q, neg_d;
    logic        down_q, down_d, fa_q, fa_d, fw_q, fw_d;
    logic [5:0]  pwm_d, pwm_en_d;
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] stb);
        merge = {stb[1] ? dat[15:8] : old[15:8],
                 stb[0] ? dat[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= tpcpwm_pkg::OFF_PRESC);
    endfunction
    logic [1:0] mode;
    logic       tick, comp, rsync, wr_go;
    logic [15:0] c3_nx, c4_nx;
    always_comb begin
        mode  = ctrl_q[tpcpwm_pkg::CTRL_MODE +: 2];
        comp  = mode == tpcpwm_pkg::MODE_COMP;
        rsync = mode == tpcpwm_pkg::MODE_RESET;
        tick  = pre_cnt_q == presc_q;
        wr_go = aw_q && w_q && !bv_q;
    end

    // Counter, compare and output logic
    logic per_hit, udf, run3, run4, up_hit;
    always_comb begin
        run3    = ctrl_q[tpcpwm_pkg::CTRL_RUN3] && tick;
        run4    = ctrl_q[tpcpwm_pkg::CTRL_RUN4] && tick;
        per_hit = c3_q == per_q;
        udf     = comp && run4 && down_q && c4_q == 16'h0000;
        up_hit  = comp && run3 && !down_q && per_hit;
        pre_cnt_d = tick ? 16'h0000 : pre_cnt_q + 16'h0001;
        presc_d = presc_q;
        ctrl_d  = ctrl_q;
        per_d   = per_q;
        down_d  = down_q;
        pos_d   = pos_q;
        neg_d   = neg_q;
        fa_d    = fa_q;
        fw_d    = fw_q;
        c3_nx   = c3_q;
        c4_nx   = c4_q;
        for (int i = 0; i < 3; i++) begin
            cmp_d[i] = cmp_q[i];
            sh_d[i]  = sh_q[i];
        end
        if (comp) begin
            if (run3) c3_nx = down_q ? c3_q - 16'h0001 : c3_q + 16'h0001;
            if (run4) c4_nx = down_q ? c4_q - 16'h0001 : c4_q + 16'h0001;
            if (up_hit) begin
                down_d = 1'b1;
                fa_d   = 1'b1;
            end
            if (udf) begin
                down_d = 1'b0;
                fw_d   = 1'b1;
            end
            // Ch3 steers positive, ch4 negative: the offset is the gap
            for (int i = 0; i < 3; i++) begin
                if (run3 && c3_q == cmp_q[i]) pos_d[i] = down_q;
                if (run4 && c4_q == cmp_q[i]) neg_d[i] = !down_q;
            end
            if ((up_hit || udf) && ctrl_q[tpcpwm_pkg::CTRL_BUF]) begin
                for (int i = 0; i < 3; i++) cmp_d[i] = sh_q[i];
            end
        end else begin
            if (run3) begin
                if (per_hit && ctrl_q[tpcpwm_pkg::CTRL_CLR]) begin
                    c3_nx = tpcpwm_pkg::CNT_RESET;
                    if (rsync) pos_d = 3'h0;
                    if (rsync && ctrl_q[tpcpwm_pkg::CTRL_BUF]) begin
                        for (int i = 0; i < 3; i++) cmp_d[i] = sh_q[i];
                    end
                end else begin
                    c3_nx = c3_q + 16'h0001;
                end
                if (per_hit) fa_d = 1'b1;
                // Compares above period never match: constant level
                for (int i = 0; i < 3; i++) begin
                    if (rsync && c3_q == cmp_q[i] && !per_hit)
                        pos_d[i] = 1'b1;
                end
            end
            // Ch4 is independent here and ignores phase 2/3 compares
            if (run4) begin
                c4_nx = c4_q + 16'h0001;
                if (c4_q == 16'hffff) fw_d = 1'b1;
            end
            down_d = 1'b0;
            neg_d  = 3'h0;
        end
        c3_d = c3_nx;
        c4_d = c4_nx;
        // Register writes; a hardware set wins over a software clear
        if (wr_go) begin
            unique case (awa_q)
                tpcpwm_pkg::OFF_CTRL:
                    ctrl_d = 6'(merge({10'h0, ctrl_q}, wd_q, wd_q[19:16]));
                tpcpwm_pkg::OFF_CNT3:   c3_d  = merge(c3_q, wd_q, 4'h3);
                tpcpwm_pkg::OFF_CNT4:   c4_d  = merge(c4_q, wd_q, 4'h3);
                tpcpwm_pkg::OFF_PERIOD: per_d = merge(per_q, wd_q, 4'h3);
                tpcpwm_pkg::OFF_PH1:    cmp_d[0] = merge(cmp_q[0], wd_q, 4'h3);
                tpcpwm_pkg::OFF_PH2:    cmp_d[1] = merge(cmp_q[1], wd_q, 4'h3);
                tpcpwm_pkg::OFF_PH3:    cmp_d[2] = merge(cmp_q[2], wd_q, 4'h3);
                tpcpwm_pkg::OFF_SH1:    sh_d[0] = merge(sh_q[0], wd_q, 4'h3);
                tpcpwm_pkg::OFF_SH2:    sh_d[1] = merge(sh_q[1], wd_q, 4'h3);
                tpcpwm_pkg::OFF_SH3:    sh_d[2] = merge(sh_q[2], wd_q, 4'h3);
                tpcpwm_pkg::OFF_STATUS: begin
                    if (!wd_q[tpcpwm_pkg::ST_MATCHA] && !(up_hit ||
                        (!comp && run3 && per_hit)))
                        fa_d = 1'b0;
                    if (!wd_q[tpcpwm_pkg::ST_WRAP] && !udf &&
                        !(!comp && run4 && c4_q == 16'hffff))
                        fw_d = 1'b0;
                end
                tpcpwm_pkg::OFF_PRESC:  presc_d = merge(presc_q, wd_q, 4'h3);
                default: ;
            endcase
        end
        // Pin drive: reset-sync negative is the plain inverse
        pwm_en_d = (comp || rsync) ? 6'h3f : 6'h00;
        for (int i = 0; i < 3; i++) begin
            pwm_d[2*i]   = pos_q[i];
            pwm_d[2*i+1] = comp ? neg_q[i] : !pos_q[i];
        end
    end

    // AXI4-Lite handshake; wstrb rides in the unused top of wd_q
    always_comb begin
        aw_d = aw_q;
        w_d  = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d  = 1'b1;
            wd_d = {12'h000, s_axi_wstrb, s_axi_wdata[15:0]};
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(awa_q) ? 2'h0 : 2'h2;
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            unique case (s_axi_araddr)
                tpcpwm_pkg::OFF_CTRL:   rd_d = {26'h0, ctrl_q};
                tpcpwm_pkg::OFF_CNT3:   rd_d = {16'h0, c3_q};
                tpcpwm_pkg::OFF_CNT4:   rd_d = {16'h0, c4_q};
                tpcpwm_pkg::OFF_PERIOD: rd_d = {16'h0, per_q};
                tpcpwm_pkg::OFF_PH1:    rd_d = {16'h0, cmp_q[0]};
                tpcpwm_pkg::OFF_PH2:    rd_d = {16'h0, cmp_q[1]};
                tpcpwm_pkg::OFF_PH3:    rd_d = {16'h0, cmp_q[2]};
                tpcpwm_pkg::OFF_SH1:    rd_d = {16'h0, sh_q[0]};
                tpcpwm_pkg::OFF_SH2:    rd_d = {16'h0, sh_q[1]};
                tpcpwm_pkg::OFF_SH3:    rd_d = {16'h0, sh_q[2]};
                tpcpwm_pkg::OFF_STATUS: rd_d = {29'h0, down_q, fw_q, fa_q};
                tpcpwm_pkg::OFF_PRESC:  rd_d = {16'h0, presc_q};
                default:                rd_d = 32'h0000_0000;
            endcase
        end
        if (rv_q && s_axi_rready) rv_d = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= 6'h00;
            c3_q      <= tpcpwm_pkg::CNT_RESET;
            c4_q      <= tpcpwm_pkg::CNT_RESET;
            per_q     <= tpcpwm_pkg::CMP_RESET;
            presc_q   <= tpcpwm_pkg::PRESC_RESET;
            pre_cnt_q <= 16'h0000;
            for (int i = 0; i < 3; i++) begin
                cmp_q[i] <= tpcpwm_pkg::CMP_RESET;
                sh_q[i]  <= tpcpwm_pkg::CMP_RESET;
            end
            pos_q    <= 3'h0;
            neg_q    <= 3'h0;
            down_q   <= 1'b0;
            fa_q     <= 1'b0;
            fw_q     <= 1'b0;
            pwm_q    <= 6'h00;
            pwm_en_q <= 6'h00;
            aw_q  <= 1'b0;
            w_q   <= 1'b0;
            awa_q <= 8'h00;
            wd_q  <= 32'h0000_0000;
            bv_q  <= 1'b0;
            br_q  <= 2'h0;
            rv_q  <= 1'b0;
            rd_q  <= 32'h0000_0000;
            rr_q  <= 2'h0;
        end else begin
            ctrl_q    <= ctrl_d;
            c3_q      <= c3_d;
            c4_q      <= c4_d;
            per_q     <= per_d;
            presc_q   <= presc_d;
            pre_cnt_q <= pre_cnt_d;
            cmp_q     <= cmp_d;
            sh_q      <= sh_d;
            pos_q     <= pos_d;
            neg_q     <= neg_d;
            down_q    <= down_d;
            fa_q      <= fa_d;
            fw_q      <= fw_d;
            pwm_q     <= pwm_d;
            pwm_en_q  <= pwm_en_d;
            aw_q  <= aw_d;
            w_q   <= w_d;
            awa_q <= awa_d;
            wd_q  <= wd_d;
            bv_q  <= bv_d;
            br_q  <= br_d;
            rv_q  <= rv_d;
            rd_q  <= rd_d;
            rr_q  <= rr_d;
        end
    end

    always_comb begin
        s_axi_awready = !aw_q;
        s_axi_wready  = !w_q;
        s_axi_bvalid  = bv_q;
        s_axi_bresp   = br_q;
        s_axi_arready = !rv_q;
        s_axi_rvalid  = rv_q;
        s_axi_rdata   = rd_q;
        s_axi_rresp   = rr_q;
    end
    default clocking cb_main @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_up_turn;
        up_hit;
    endsequence
    a_turn_down: assert property (s_up_turn |=> down_q)
        else $error("no turn down");
    a_turn_up: assert property (udf |=> !down_q && fw_q)
        else $error("no turn up");
    a_matcha_up: assert property (
        comp && $rose(fa_q) |-> !$past(down_q))
        else $error("fa down");
    a_buf_copy: assert property (
        (up_hit || udf) && ctrl_q[tpcpwm_pkg::CTRL_BUF] && !wr_go
        |=> cmp_q[0] == $past(sh_q[0])) else $error("no copy");
    a_rs_clear: assert property (
        !comp && run3 && per_hit && ctrl_q[tpcpwm_pkg::CTRL_CLR] && !wr_go
        |=> c3_q == 16'h0000) else $error("no clear");
    a_pins_on: assert property (rsync |=> pwm_en_q == 6'h3f)
        else $error("pins off");
    a_rs_toggle: assert property (
        rsync && run3 && per_hit && ctrl_q[tpcpwm_pkg::CTRL_CLR]
        |=> pos_q == 3'h0) else $error("no reset");
    a_no_overlap: assert property (
        comp && $past(comp) |-> !(pwm_q[0] && pwm_q[1]))
        else $error("overlap");
    a_ch4_free: assert property (
        rsync && run4 && !wr_go |=> c4_q == $past(c4_q) + 16'h0001)
        else $error("ch4 stuck");
    a_ch3_above: assert property (
        comp && run3 && per_hit && !down_q |-> c3_q != c4_q)
        else $error("ch3 equals ch4");
    a_const_duty: assert property (
        rsync && !(run3 && per_hit) && cmp_q[2] > per_q && c3_q <= per_q
        |=> $stable(pos_q[2])) else $error("duty moved");
endmodule

// [shared/tpcpwm_pkg.sv]
// Package for the three-phase complementary PWM block: register map,
// field positions, reset values and mode codes.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package tpcpwm_pkg;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CNT3    = 8'h04;
    localparam logic [7:0] OFF_CNT4    = 8'h08;
    localparam logic [7:0] OFF_PERIOD  = 8'h0c;
    localparam logic [7:0] OFF_PH1     = 8'h10;
    localparam logic [7:0] OFF_PH2     = 8'h14;
    localparam logic [7:0] OFF_PH3     = 8'h18;
    localparam logic [7:0] OFF_SH1     = 8'h1c;
    localparam logic [7:0] OFF_SH2     = 8'h20;
    localparam logic [7:0] OFF_SH3     = 8'h24;
    localparam logic [7:0] OFF_STATUS  = 8'h28;
    localparam logic [7:0] OFF_PRESC   = 8'h2c;

    // Control register fields
    localparam int CTRL_RUN3   = 0;
    localparam int CTRL_RUN4   = 1;
    localparam int CTRL_MODE   = 2;   // 2 bits, combined mode
    localparam int CTRL_CLR    = 4;   // 1 = clear ch3 on period match
    localparam int CTRL_BUF    = 5;   // Buffer mode enable
    // Status register fields
    localparam int ST_MATCHA   = 0;
    localparam int ST_WRAP     = 1;
    localparam int ST_DOWN     = 2;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_RESET  = 2'h2;
    localparam logic [1:0] MODE_COMP   = 2'h3;

    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] CMP_RESET    = 16'hffff;
    localparam logic [15:0] PRESC_RESET  = 16'h0000;
endpackage
